// ---- rtl/lmg_pkg.sv ----
// Purpose: Shared constants and carriers for the line monitor global control bank
// Assumes: 8-bit register port, eight channels
// Notes: Offsets are byte addresses on the plain register port
package lmg_pkg;
    // Register offsets
    localparam logic [7:0] LMG_OFF_LOSS = 8'h04;
    localparam logic [7:0] LMG_OFF_SRST = 8'h0A;
    localparam logic [7:0] LMG_OFF_MON = 8'h0B;
    localparam logic [7:0] LMG_OFF_DLB = 8'h0C;
    localparam logic [7:0] LMG_OFF_LASS = 8'h0D;
    localparam logic [7:0] LMG_OFF_AAO = 8'h0E;
    localparam logic [7:0] LMG_OFF_GCTL = 8'h0F;
    // Reset value of every register
    localparam logic [7:0] LMG_RST_VAL = 8'h00;
    // Global control field positions
    localparam int LMG_G_AUTOINC = 7;
    localparam int LMG_G_RXAIS = 6;
    localparam int LMG_G_CODE = 4;
    localparam int LMG_G_DEPTH = 3;
    localparam int LMG_G_CORNER = 2;
    localparam int LMG_G_JAPOS = 0;
    // Monitor selector field: direction bit and channel
    localparam int LMG_M_DIR = 3;
    localparam int LMG_M_CH = 0;

    // Jitter attenuator placement
    typedef enum logic [1:0] {
        LMG_JA_OFF,
        LMG_JA_TX,
        LMG_JA_RX
    } lmg_ja_e;

    // Registered control outputs toward the datapaths
    typedef struct packed {
        logic mon_en;
        logic mon_tx;
        logic [2:0] mon_ch;
        logic [7:0] dlb;
        logic t1231;
        logic [7:0] etsi;
        logic [7:0] g775;
        logic [7:0] transmit_all_ones;
        logic [7:0] rx_ais;
        logic ami;
        logic depth64;
        logic corner_hi;
        lmg_ja_e ja_pos;
        logic wave_inc;
    } lmg_out_s;
endpackage : lmg_pkg

// ---- rtl/lmg_regs.sv ----
// Purpose: Monitor selector, loopback, loss standard, auto all-ones and global control
// Assumes: One 250 MHz clock, synchronous active-high reset, loss inputs from pins
// Notes: All control outputs are registered and lag a write by two cycles
`timescale 1ns/1ps

module lmg_regs
    import lmg_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic t1_mode_i,
    input wire logic [7:0] los_pin_i,
    input wire logic [7:0] manual_all_ones_i,
    input wire logic wave_access_i,
    output logic monitor_en_o,
    output logic monitor_tx_o,
    output logic [2:0] monitor_ch_o,
    output logic [7:0] loopback_en_o,
    output logic los_t1231_o,
    output logic [7:0] los_etsi_o,
    output logic [7:0] los_g775_o,
    output logic [7:0] transmit_all_ones_o,
    output logic [7:0] rx_alarm_insert_o,
    output logic line_code_ami_o,
    output logic jitter_depth64_o,
    output logic jitter_corner_hi_o,
    output logic jitter_tx_o,
    output logic jitter_rx_o,
    output logic waveform_addr_inc_o
);

    // Whole state of the bank in one carrier
    typedef struct packed {
        logic [7:0] mon;
        logic [7:0] dlb;
        logic [7:0] lass;
        logic [7:0] aao;
        logic [7:0] gctl;
        logic [7:0] los_meta;
        logic [7:0] los_sync;
        logic [7:0] rdata;
        lmg_out_s out;
    } lmg_state_s;

    lmg_state_s st_reg; // Registered state
    lmg_state_s st_next; // Next state
    logic [7:0] code_sel; // Global line code copied to each channel
    logic [7:0] loss_qual; // Loss with automatic all-ones enable

    // Next-state logic: register port, synchroniser and output decode
    always_comb begin
        st_next = st_reg;
        st_next.rdata = LMG_RST_VAL; // Read data valid only one cycle
        // Two-stage sync; first stage feeds only the second
        st_next.los_meta = los_pin_i;
        st_next.los_sync = st_reg.los_meta;
        // Register writes
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                LMG_OFF_MON: st_next.mon = reg_wdata_i;
                LMG_OFF_DLB: st_next.dlb = reg_wdata_i;
                LMG_OFF_LASS: st_next.lass = reg_wdata_i;
                LMG_OFF_AAO: st_next.aao = reg_wdata_i;
                LMG_OFF_GCTL: st_next.gctl = reg_wdata_i;
                LMG_OFF_SRST: begin
                    // Any value resets the whole bank
                    st_next.mon = LMG_RST_VAL;
                    st_next.dlb = LMG_RST_VAL;
                    st_next.lass = LMG_RST_VAL;
                    st_next.aao = LMG_RST_VAL;
                    st_next.gctl = LMG_RST_VAL;
                end
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
        // Register reads, answered next cycle
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                LMG_OFF_LOSS: st_next.rdata = st_reg.los_sync;
                LMG_OFF_MON: st_next.rdata = st_reg.mon;
                LMG_OFF_DLB: st_next.rdata = st_reg.dlb;
                LMG_OFF_LASS: st_next.rdata = st_reg.lass;
                LMG_OFF_AAO: st_next.rdata = st_reg.aao;
                LMG_OFF_GCTL: st_next.rdata = st_reg.gctl;
                default: st_next.rdata = LMG_RST_VAL; // Unmapped reads zero
            endcase
        end
        // Monitor routing; bits 7:4 are reserved and do not steer
        st_next.out.mon_ch = st_reg.mon[LMG_M_CH +: 3];
        st_next.out.mon_en = (st_reg.mon[LMG_M_CH +: 3] != 3'h0);
        st_next.out.mon_tx = st_reg.mon[LMG_M_DIR];
        st_next.out.dlb = st_reg.dlb;
        // Standard select only counts in E1 mode
        st_next.out.t1231 = t1_mode_i;
        st_next.out.etsi = t1_mode_i ? 8'h00 : st_reg.lass;
        st_next.out.g775 = t1_mode_i ? 8'h00 : ~st_reg.lass;
        st_next.out.transmit_all_ones = manual_all_ones_i | loss_qual;
        st_next.out.rx_ais = st_reg.gctl[LMG_G_RXAIS] ? st_reg.los_sync : 8'h00;
        st_next.out.ami = st_reg.gctl[LMG_G_CODE];
        st_next.out.depth64 = st_reg.gctl[LMG_G_DEPTH];
        st_next.out.corner_hi = st_reg.gctl[LMG_G_CORNER];
        // Both codes with bit 0 low decode as off
        unique case (st_reg.gctl[LMG_G_JAPOS +: 2])
            2'h1: st_next.out.ja_pos = LMG_JA_TX;
            2'h3: st_next.out.ja_pos = LMG_JA_RX;
            2'h0, 2'h2: st_next.out.ja_pos = LMG_JA_OFF;
        endcase
        // Step pulse is only as good as the enable order kept by software
        st_next.out.wave_inc = wave_access_i & st_reg.gctl[LMG_G_AUTOINC];
    end

    // Per-channel qualification of the automatic all-ones request
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            // Loss on channel gi only matters when its auto bit is set
            assign loss_qual[gi] = st_reg.aao[gi] & st_reg.los_sync[gi];
            // Per-channel line code view, kept global
            assign code_sel[gi] = st_reg.out.ami;
        end
    endgenerate

    // State register with synchronous reset
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from flip-flops; attenuator enables decoded from the registered position
    assign reg_rdata_o = st_reg.rdata;
    assign monitor_en_o = st_reg.out.mon_en;
    assign monitor_tx_o = st_reg.out.mon_tx;
    assign monitor_ch_o = st_reg.out.mon_ch;
    assign loopback_en_o = st_reg.out.dlb;
    assign los_t1231_o = st_reg.out.t1231;
    assign los_etsi_o = st_reg.out.etsi;
    assign los_g775_o = st_reg.out.g775;
    assign transmit_all_ones_o = st_reg.out.transmit_all_ones;
    assign rx_alarm_insert_o = st_reg.out.rx_ais;
    assign line_code_ami_o = &code_sel;
    assign jitter_depth64_o = st_reg.out.depth64;
    assign jitter_corner_hi_o = st_reg.out.corner_hi;
    assign jitter_tx_o = (st_reg.out.ja_pos == LMG_JA_TX);
    assign jitter_rx_o = (st_reg.out.ja_pos == LMG_JA_RX);
    assign waveform_addr_inc_o = st_reg.out.wave_inc;

    // Checks share one clock and the reset
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    // Bank is clear in the first cycle after reset
    reset_clear_a: assert property (
        $past(sys_rst_i) |-> (st_reg.gctl == 8'h00) && (st_reg.mon == 8'h00)
            && (st_reg.aao == 8'h00) && (reg_rdata_o == 8'h00))
        else $error("bank not clear after reset");

    // Monitor outputs follow the selector nibble
    monitor_route_a: assert property (
        reg_wr_i && reg_addr_i == LMG_OFF_MON |-> ##2
            (monitor_en_o == (($past(reg_wdata_i, 2) & 8'h07) != 8'h00))
            && (monitor_tx_o == $past(reg_wdata_i[3], 2))
            && (monitor_ch_o == $past(reg_wdata_i[2:0], 2)))
        else $error("monitor routing mismatch");

    // Loopback enables reach the outputs two cycles after the write
    loopback_write_a: assert property (
        reg_wr_i && reg_addr_i == LMG_OFF_DLB |-> ##2
            loopback_en_o == $past(reg_wdata_i, 2))
        else $error("loopback enables wrong");

    // T1/J1 mode masks both E1 standards
    t1_standard_a: assert property (
        t1_mode_i |=> los_t1231_o && los_etsi_o == 8'h00 && los_g775_o == 8'h00)
        else $error("standard select not ignored in T1");

    // E1 mode splits channels by the select bits
    e1_standard_a: assert property (
        !t1_mode_i |=> los_etsi_o == $past(st_reg.lass) && los_g775_o == ~los_etsi_o)
        else $error("E1 standard select wrong");

    // All-ones from manual or loss with auto enable
    all_ones_a: assert property (
        ##1 transmit_all_ones_o == ($past(manual_all_ones_i)
            | ($past(st_reg.aao) & $past(st_reg.los_sync))))
        else $error("all-ones request wrong");

    // Each waveform access steps the address when enabled
    autoinc_step_a: assert property (
        wave_access_i |=> waveform_addr_inc_o == $past(st_reg.gctl[7]))
        else $error("waveform step pulse wrong");

    // Receive AIS follows loss only when enabled
    rx_alarm_a: assert property (
        !st_reg.gctl[6] |=> rx_alarm_insert_o == 8'h00)
        else $error("receive AIS while disabled");

    // Global bits steer code, depth, corner and position
    global_decode_a: assert property (
        reg_wr_i && reg_addr_i == LMG_OFF_GCTL |-> ##2
            line_code_ami_o == $past(reg_wdata_i[4], 2)
            && jitter_depth64_o == $past(reg_wdata_i[3], 2)
            && jitter_corner_hi_o == $past(reg_wdata_i[2], 2)
            && jitter_rx_o == ($past(reg_wdata_i[1:0], 2) == 2'h3)
            && jitter_tx_o == ($past(reg_wdata_i[1:0], 2) == 2'h1))
        else $error("global control decode wrong");

    // Soft reset write clears the bank
    soft_reset_a: assert property (
        reg_wr_i && reg_addr_i == LMG_OFF_SRST |=>
            st_reg.mon == 8'h00 && st_reg.dlb == 8'h00 && st_reg.lass == 8'h00
            && st_reg.aao == 8'h00 && st_reg.gctl == 8'h00)
        else $error("soft reset left a register set");

    // Loss status read shows synchronised loss
    loss_read_a: assert property (
        reg_rd_i && reg_addr_i == LMG_OFF_LOSS |=> reg_rdata_o == $past(st_reg.los_sync))
        else $error("loss status read wrong");

    // Write then read returns the written byte
    read_back_a: assert property (
        reg_wr_i && reg_addr_i == LMG_OFF_GCTL ##1 reg_rd_i && reg_addr_i == LMG_OFF_GCTL
            |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("read back mismatch");

    // Read data returns to zero when no read was strobed
    read_idle_a: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data left standing");

    // Soft reset register is write-only and reads zero
    srst_read_a: assert property (
        reg_rd_i && reg_addr_i == LMG_OFF_SRST |=> reg_rdata_o == 8'h00)
        else $error("soft reset register read not zero");

    // Attenuator sits in one path at most
    jitter_onehot_a: assert property (
        !(jitter_tx_o && jitter_rx_o))
        else $error("attenuator in both paths");

    // Disabled monitoring always carries channel code zero
    monitor_off_a: assert property (
        !monitor_en_o |-> monitor_ch_o == 3'h0)
        else $error("monitor off with a channel");

    // Receive AIS copies synchronised loss when enabled
    rx_alarm_on_a: assert property (
        st_reg.gctl[LMG_G_RXAIS] |=> rx_alarm_insert_o == $past(st_reg.los_sync))
        else $error("receive AIS does not follow loss");

    // Loopback byte only moves on its own write or a soft reset
    loopback_hold_a: assert property (
        !(reg_wr_i && (reg_addr_i == LMG_OFF_DLB || reg_addr_i == LMG_OFF_SRST))
            |=> $stable(st_reg.dlb))
        else $error("loopback changed without a write");

    // Global byte only moves on its own write or a soft reset
    global_hold_a: assert property (
        !(reg_wr_i && (reg_addr_i == LMG_OFF_GCTL || reg_addr_i == LMG_OFF_SRST))
            |=> $stable(st_reg.gctl))
        else $error("global control changed without a write");

    // No step pulse without a waveform access
    wave_idle_a: assert property (
        !wave_access_i |=> !waveform_addr_inc_o)
        else $error("step pulse without access");

    // E1 mode never claims the T1 criteria
    e1_no_t1231_a: assert property (
        !t1_mode_i |=> !los_t1231_o)
        else $error("T1 criteria flagged in E1 mode");

endmodule : lmg_regs

// ---- tb/lmg_regs_test.sv ----
// Purpose: Self-checking bench for the monitor selector and global control bank
// Assumes: Read data stands one cycle after the read strobe, outputs lag a write by two
// Notes: All waits are fixed counts from the hand-over timing, so none can hang
`timescale 1ns/1ps
module lmg_regs_test import lmg_pkg::*;;
    // Design inputs, named as the ports
    logic clk_sys_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic t1_mode_i = 1'b0;
    logic [7:0] los_pin_i = 8'h00;
    logic [7:0] manual_all_ones_i = 8'h00;
    logic wave_access_i = 1'b0;
    // Design outputs
    logic [7:0] reg_rdata_o, loopback_en_o, los_etsi_o, los_g775_o;
    logic [7:0] transmit_all_ones_o, rx_alarm_insert_o;
    logic monitor_en_o, monitor_tx_o, los_t1231_o, line_code_ami_o, jitter_depth64_o;
    logic jitter_corner_hi_o, jitter_tx_o, jitter_rx_o, waveform_addr_inc_o;
    logic [2:0] monitor_ch_o;
    // Tallies
    int bad_count = 0;
    int total_checks = 0;
    // Writable offsets in address order
    logic [7:0] offs [5] = '{LMG_OFF_MON, LMG_OFF_DLB, LMG_OFF_LASS, LMG_OFF_AAO, LMG_OFF_GCTL};

    lmg_regs i_dut (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .t1_mode_i, .los_pin_i, .manual_all_ones_i, .wave_access_i,
        .monitor_en_o, .monitor_tx_o, .monitor_ch_o, .loopback_en_o, .los_t1231_o,
        .los_etsi_o, .los_g775_o, .transmit_all_ones_o, .rx_alarm_insert_o,
        .line_code_ami_o, .jitter_depth64_o, .jitter_corner_hi_o, .jitter_tx_o,
        .jitter_rx_o, .waveform_addr_inc_o);

    // 250 MHz clock
    always #2 clk_sys_i = ~clk_sys_i;

    // Byte compare; four-state so an unknown never matches
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One-cycle write strobe
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : wr_reg

    // One-cycle read strobe; data looked at only in the following cycle
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("read data", exp, reg_rdata_o);
    endtask : rd_chk

    // Write followed at once by a read of the same offset, no gap
    task wr_rd_chk(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("read back", d, reg_rdata_o);
    endtask : wr_rd_chk

    // Let the two-stage control outputs land
    task settle;
        repeat (3) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
    endtask : settle

    // Waveform access pulse; the step pulse must follow one cycle later only
    task wave_pulse(input logic exp);
        @(posedge clk_sys_i);
        wave_access_i <= 1'b1;
        @(posedge clk_sys_i);
        wave_access_i <= 1'b0;
        @(negedge clk_sys_i);
        chk("addr step", {7'h00, exp}, {7'h00, waveform_addr_inc_o});
        @(negedge clk_sys_i);
        chk("step end", 8'h00, {7'h00, waveform_addr_inc_o});
    endtask : wave_pulse

    // Verdict, reached from one place only
    task results;
        $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'b0;
        settle();
        chk("transmit_all_ones", 8'h00, transmit_all_ones_o);
        for (int i = 0; i < 5; i++) rd_chk(offs[i], LMG_RST_VAL);
        // Bytes 8'h08 to 8'h0C stored and read back, reserved bits left zero; unmapped and status writes ignored
        for (int i = 0; i < 5; i++) wr_reg(offs[i], 8'h08 | 8'(i));
        wr_reg(8'h30, 8'hFF);
        wr_reg(LMG_OFF_LOSS, 8'hFF);
        for (int i = 0; i < 5; i++) rd_chk(offs[i], 8'h08 | 8'(i));
        rd_chk(8'h30, 8'h00);
        rd_chk(LMG_OFF_LOSS, 8'h00);
        wr_rd_chk(LMG_OFF_GCTL, 8'h1D);
        // Every selector code
        for (int c = 0; c < 16; c++) begin
            wr_reg(LMG_OFF_MON, 8'(c));
            settle();
            chk("monitor", {3'h0, c[2:0] != 3'h0, c[3], c[2:0]},
                {3'h0, monitor_en_o, monitor_tx_o, monitor_ch_o});
        end
        wr_reg(LMG_OFF_DLB, 8'hA5);
        settle();
        chk("loopback", 8'hA5, loopback_en_o);
        // Standard select in E1 mode, then ignored in T1 mode
        wr_reg(LMG_OFF_LASS, 8'h3C);
        settle();
        chk("etsi", 8'h3C, los_etsi_o);
        chk("g775", 8'hC3, los_g775_o);
        @(posedge clk_sys_i);
        t1_mode_i <= 1'b1;
        settle();
        chk("t1 sel", 8'h01, {7'h00, los_t1231_o});
        chk("t1 etsi", 8'h00, los_etsi_o | los_g775_o);
        // Every combination of the low global fields
        for (int g = 0; g < 32; g++) begin
            wr_reg(LMG_OFF_GCTL, 8'(g));
            settle();
            chk("global", {3'h0, g[4], g[3], g[2], g[1:0] == 2'b01, g[1:0] == 2'b11},
                {3'h0, line_code_ami_o, jitter_depth64_o, jitter_corner_hi_o,
                jitter_tx_o, jitter_rx_o});
        end
        // Loss with automatic actions off: only the manual request shows
        wr_reg(LMG_OFF_GCTL, 8'h00);
        wr_reg(LMG_OFF_AAO, 8'h00);
        manual_all_ones_i <= 8'h10;
        los_pin_i <= 8'h81;
        settle();
        chk("transmit_all_ones off", 8'h10, transmit_all_ones_o);
        chk("ais off", 8'h00, rx_alarm_insert_o);
        rd_chk(LMG_OFF_LOSS, 8'h81);
        wr_reg(LMG_OFF_AAO, 8'h03);
        wr_reg(LMG_OFF_GCTL, 8'h40);
        settle();
        chk("transmit_all_ones auto", 8'h11, transmit_all_ones_o);
        chk("ais on", 8'h81, rx_alarm_insert_o);
        @(posedge clk_sys_i);
        los_pin_i <= 8'h00;
        settle();
        chk("transmit_all_ones clear", 8'h10, transmit_all_ones_o);
        // Address step only while the auto-increment bit is set
        wave_pulse(1'b0);
        wr_reg(LMG_OFF_GCTL, 8'h80);
        settle();
        wave_pulse(1'b1);
        // Software reset clears the whole bank
        wr_reg(LMG_OFF_SRST, 8'h5A);
        for (int i = 0; i < 5; i++) rd_chk(offs[i], LMG_RST_VAL);
        settle();
        chk("lb reset", 8'h00, loopback_en_o);
        results();
    end
endmodule : lmg_regs_test
